// ### hdl/bate_consts.svh
// Constants for the bit and transfer execution unit
`ifndef BATE_CONSTS_SVH
`define BATE_CONSTS_SVH

// ****************************************************************
// Status flag positions
// ****************************************************************
`define BATE_FLAG_C 3'h0
`define BATE_FLAG_Z 3'h1
`define BATE_FLAG_N 3'h2
`define BATE_FLAG_V 3'h3
`define BATE_FLAG_S 3'h4
`define BATE_FLAG_H 3'h5
`define BATE_FLAG_T 3'h6
`define BATE_FLAG_I 3'h7

// ****************************************************************
// Register file layout and reset values
// ****************************************************************
`define BATE_PAIR_X 5'h1a
`define BATE_PAIR_Y 5'h1c
`define BATE_PAIR_Z 5'h1e
`define BATE_REG_ZERO 5'h00
`define BATE_FLAGS_RESET 8'h00
`define BATE_SP_RESET 16'hffff
`define BATE_CODE_PAGE_RESET 8'h00
`define BATE_CODE_PAGE_IO 6'h30

`endif

// ### hdl/bate_pkg.sv
// Types for the bit and transfer execution unit
package bate_pkg;

	// ****************************************************************
	// Operation codes handed over by the instruction decoder
	// ****************************************************************
	typedef enum logic [4:0]
	{
		OP_NONE,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_LOGICAL_LEFT_SHIFT,
		OP_LOGICAL_RIGHT_SHIFT,
		OP_CARRY_ROTATE_LEFT,
		OP_CARRY_ROTATE_RIGHT,
		OP_SIGN_RIGHT_SHIFT,
		OP_NIBBLE_EXCHANGE,
		OP_FLAG_SET,
		OP_FLAG_CLEAR,
		OP_BIT_TO_TFLAG,
		OP_TFLAG_TO_BIT,
		OP_REG_MOVE,
		OP_PAIR_COPY,
		OP_IMMEDIATE_LOAD,
		OP_PORT_READ,
		OP_PORT_WRITE,
		OP_INDIRECT_LOAD,
		OP_INDIRECT_STORE,
		OP_DIRECT_LOAD,
		OP_DIRECT_STORE,
		OP_CODE_READ,
		OP_EXT_CODE_READ,
		OP_CODE_WRITE,
		OP_STACK_PUSH,
		OP_STACK_POP
	} bate_opc_t;

	typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} bate_ptr_t;

	typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP} bate_mode_t;

	// One decoded operation with all its operands
	typedef struct packed
	{
		bate_opc_t opc;
		logic [4:0] dst;
		logic [4:0] src;
		logic [2:0] bit_sel;
		logic [7:0] imm;
		logic [15:0] addr;
		logic [5:0] io_addr;
		bate_ptr_t ptr;
		bate_mode_t mode;
		logic [5:0] disp;
		logic implied;
	} bate_op_t;

	// Data space or I/O space request
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} bate_mreq_t;

	// Program memory read request, byte address
	typedef struct packed
	{
		logic [23:0] addr;
		logic re;
	} bate_preq_t;

endpackage

// ### hdl/bate_exec.sv
// Execution unit for bit manipulation and data transfer operations
`timescale 1ns/100ps
`include "bate_consts.svh"

// Functional notes
// - I/O bit set/clear, flags kept, two cycles
// - Left shift fills zero, Z C N V
// - Right shift fills zero, Z C N V
// - Rotate left through carry, Z C N V
// - Rotate right through carry, Z C N V
// - Arithmetic right shift keeps bit seven
// - Nibble swap, no flags, one cycle
// - Flag set/clear touches only target flag
// - Copy register bit into T flag
// - Copy T flag into register bit
// - Indirect load then pointer increment, two cycles
// - Pointer decrement then indirect load, two cycles
// - Displaced load from Y/Z, pointer kept
// - Indirect store then pointer increment, two cycles
// - Pointer decrement then indirect store, two cycles
// - Displaced store to Y/Z, pointer kept
// - Direct load, two cycles, no flags
// - Direct store, two cycles, no flags
// - Code read via Z, three cycles
// - Extended code read uses page:Z, increments whole
// - Push stores source, two cycles
// - Pop loads destination, two cycles
module bate_exec #(
	parameter logic [15:0] SP_RESET = `BATE_SP_RESET,
	parameter logic [5:0] CODE_PAGE_IO = `BATE_CODE_PAGE_IO
)(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire bate_pkg::bate_op_t op,
	output logic op_ready,
	output bate_pkg::bate_mreq_t dmem_req,
	input wire logic [7:0] dmem_rdata,
	output bate_pkg::bate_mreq_t io_req,
	input wire logic [7:0] io_rdata,
	output bate_pkg::bate_preq_t pmem_req,
	input wire logic [7:0] pmem_rdata,
	output logic spm_req,
	output logic [15:0] spm_addr,
	output logic [15:0] spm_word,
	input wire logic spm_done,
	output logic [7:0] status_flags,
	output logic [7:0] code_page,
	output logic [15:0] stack_ptr,
	input wire logic [4:0] view_sel,
	output logic [7:0] view_data
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Reads a register pair, low byte at the even index
	function automatic logic [15:0] pair_rd(input logic [31:0][7:0] rf, input logic [4:0] base);
		pair_rd = {rf[base + 5'h01], rf[base]};
	endfunction

	// Register index of the pointer pair
	function automatic logic [4:0] ptr_base(input bate_pkg::bate_ptr_t p);
		ptr_base = (p == bate_pkg::PTR_X) ? `BATE_PAIR_X :
			(p == bate_pkg::PTR_Y) ? `BATE_PAIR_Y : `BATE_PAIR_Z;
	endfunction

	// One-hot mask of a bit position
	function automatic logic [7:0] bit_mask(input logic [2:0] b);
		bit_mask = 8'h01 << b;
	endfunction

	// Shift and rotate unit, returns {carry out, result}
	function automatic logic [8:0] shift_res(input bate_pkg::bate_opc_t o, input logic [7:0] v,
		input logic c);
		unique case (o)
			bate_pkg::OP_LOGICAL_LEFT_SHIFT: shift_res = {v[7], v[6:0], 1'b0};
			bate_pkg::OP_LOGICAL_RIGHT_SHIFT: shift_res = {v[0], 1'b0, v[7:1]};
			bate_pkg::OP_CARRY_ROTATE_LEFT: shift_res = {v[7], v[6:0], c};
			bate_pkg::OP_CARRY_ROTATE_RIGHT: shift_res = {v[0], c, v[7:1]};
			default: shift_res = {v[0], v[7], v[7:1]};
		endcase
	endfunction

	// Updates Z C N V after a shift; overflow is N xor C, other flags kept
	function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
		input logic c);
		logic [7:0] t;
		t = f;
		t[`BATE_FLAG_Z] = (r == 8'h00);
		t[`BATE_FLAG_C] = c;
		t[`BATE_FLAG_N] = r[7];
		t[`BATE_FLAG_V] = r[7] ^ c;
		shift_flags = t;
	endfunction

	// ****************************************************************
	// State and storage
	// ****************************************************************
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_LOAD,
		ST_IO_WRITE,
		ST_TAIL,
		ST_PM_WAIT,
		ST_PM_CAPTURE,
		ST_SPM_WAIT
	} bate_state_t;

	bate_state_t st_ff;
	bate_state_t nxt_st;
	logic [31:0][7:0] rf_ff;
	logic [31:0][7:0] nxt_rf;
	logic [7:0] flags_ff;
	logic [7:0] nxt_flags;
	logic [15:0] sp_ff;
	logic [15:0] nxt_sp;
	logic [7:0] cp_ff;
	logic [7:0] nxt_cp;
	logic [4:0] pend_dst_ff;
	logic [5:0] io_addr_ff;
	logic [7:0] io_byte_ff;
	logic [7:0] view_ff;

	// ****************************************************************
	// Operand decode and address generation
	// ****************************************************************
	wire logic take = op_valid && (st_ff == ST_IDLE);
	wire bate_pkg::bate_opc_t opc = op.opc;
	wire logic [4:0] pbase = ptr_base(op.ptr);
	wire logic [15:0] ptr_val = pair_rd(rf_ff, pbase);
	wire logic [15:0] ptr_inc = ptr_val + 16'h0001;
	wire logic [15:0] ptr_dec = ptr_val - 16'h0001;
	wire logic [15:0] disp_addr = ptr_val + {10'h000, op.disp};
	wire logic [15:0] z_val = pair_rd(rf_ff, `BATE_PAIR_Z);
	wire logic [23:0] ext_z = {cp_ff, z_val};
	wire logic [23:0] ext_z_inc = ext_z + 24'h000001;
	wire logic [15:0] sp_inc = sp_ff + 16'h0001;
	wire logic [7:0] src_val = rf_ff[op.src];
	wire logic [7:0] dst_val = rf_ff[op.dst];
	wire logic [8:0] sh = shift_res(opc, dst_val, flags_ff[`BATE_FLAG_C]);
	wire logic [4:0] dst_even = {op.dst[4:1], 1'b0};
	wire logic [4:0] src_even = {op.src[4:1], 1'b0};

	wire logic is_shift = (opc == bate_pkg::OP_LOGICAL_LEFT_SHIFT) ||
		(opc == bate_pkg::OP_LOGICAL_RIGHT_SHIFT) || (opc == bate_pkg::OP_CARRY_ROTATE_LEFT) ||
		(opc == bate_pkg::OP_CARRY_ROTATE_RIGHT) || (opc == bate_pkg::OP_SIGN_RIGHT_SHIFT);
	wire logic is_io_bit = (opc == bate_pkg::OP_IO_BIT_SET) || (opc == bate_pkg::OP_IO_BIT_CLEAR);
	wire logic is_dload = (opc == bate_pkg::OP_INDIRECT_LOAD) ||
		(opc == bate_pkg::OP_DIRECT_LOAD) || (opc == bate_pkg::OP_STACK_POP);
	wire logic is_dstore = (opc == bate_pkg::OP_INDIRECT_STORE) ||
		(opc == bate_pkg::OP_DIRECT_STORE) || (opc == bate_pkg::OP_STACK_PUSH);
	wire logic is_code = (opc == bate_pkg::OP_CODE_READ) || (opc == bate_pkg::OP_EXT_CODE_READ);
	wire logic is_indirect = (opc == bate_pkg::OP_INDIRECT_LOAD) ||
		(opc == bate_pkg::OP_INDIRECT_STORE);

	// Pre-decrement addresses with the new pointer, displacement leaves it alone
	wire logic [15:0] ind_addr = (op.mode == bate_pkg::AM_PRE_DEC) ? ptr_dec :
		(op.mode == bate_pkg::AM_DISP) ? disp_addr : ptr_val;

	// Stack grows downward: push writes at SP, pop reads at SP plus one
	wire logic [15:0] dmem_addr =
		((opc == bate_pkg::OP_DIRECT_LOAD) || (opc == bate_pkg::OP_DIRECT_STORE)) ? op.addr :
		(opc == bate_pkg::OP_STACK_PUSH) ? sp_ff :
		(opc == bate_pkg::OP_STACK_POP) ? sp_inc : ind_addr;

	// ****************************************************************
	// Bus requests, issued in the cycle the operation is taken, except the io bit write one cycle later
	// ****************************************************************
	assign op_ready = (st_ff == ST_IDLE);
	assign dmem_req.addr = dmem_addr;
	assign dmem_req.wdata = src_val;
	assign dmem_req.re = take && is_dload;
	assign dmem_req.we = take && is_dstore;

	// The io bit write goes out one cycle after the read, from the captured byte
	assign io_req.addr = {10'h000, (st_ff == ST_IO_WRITE) ? io_addr_ff : op.io_addr};
	assign io_req.wdata = (st_ff == ST_IO_WRITE) ? io_byte_ff : src_val;
	assign io_req.re = take && (is_io_bit || (opc == bate_pkg::OP_PORT_READ));
	assign io_req.we = (take && (opc == bate_pkg::OP_PORT_WRITE)) ||
		(st_ff == ST_IO_WRITE);

	// Code reads: page byte joins above Z only for the extended form
	assign pmem_req.addr = (opc == bate_pkg::OP_EXT_CODE_READ) ? ext_z : {8'h00, z_val};
	assign pmem_req.re = take && is_code;

	// Self-programming request: word from R1:R0, address from Z
	assign spm_req = take && (opc == bate_pkg::OP_CODE_WRITE);
	assign spm_addr = z_val;
	assign spm_word = {rf_ff[1], rf_ff[0]};

	assign status_flags = flags_ff;
	assign code_page = cp_ff;
	assign stack_ptr = sp_ff;
	assign view_data = view_ff;

	// ****************************************************************
	// Register file, flags, stack pointer and page next values
	// ****************************************************************
	// Late captures are applied last so a load result wins over a pointer write
	always_comb
	begin
		nxt_rf = rf_ff;
		nxt_flags = flags_ff;
		nxt_sp = sp_ff;
		nxt_cp = cp_ff;
		if (take)
		begin
			unique case (opc)
				bate_pkg::OP_NIBBLE_EXCHANGE:
					nxt_rf[op.dst] = {dst_val[3:0], dst_val[7:4]};
				bate_pkg::OP_FLAG_SET:
					nxt_flags[op.bit_sel] = 1'b1;
				bate_pkg::OP_FLAG_CLEAR:
					nxt_flags[op.bit_sel] = 1'b0;
				bate_pkg::OP_BIT_TO_TFLAG:
					nxt_flags[`BATE_FLAG_T] = src_val[op.bit_sel];
				bate_pkg::OP_TFLAG_TO_BIT:
					nxt_rf[op.dst][op.bit_sel] = flags_ff[`BATE_FLAG_T];
				bate_pkg::OP_REG_MOVE:
					nxt_rf[op.dst] = src_val;
				bate_pkg::OP_PAIR_COPY:
				begin
					nxt_rf[dst_even] = rf_ff[src_even];
					nxt_rf[dst_even + 5'h01] = rf_ff[src_even + 5'h01];
				end
				bate_pkg::OP_IMMEDIATE_LOAD:
					nxt_rf[op.dst] = op.imm;
				bate_pkg::OP_PORT_READ:
					nxt_rf[op.dst] = io_rdata;
				bate_pkg::OP_PORT_WRITE:
					if (op.io_addr == CODE_PAGE_IO)
						nxt_cp = src_val;
				bate_pkg::OP_CODE_READ:
					if (op.mode == bate_pkg::AM_POST_INC)
						{nxt_rf[`BATE_PAIR_Z + 5'h01], nxt_rf[`BATE_PAIR_Z]} = z_val + 16'h0001;
				bate_pkg::OP_EXT_CODE_READ:
					if (op.mode == bate_pkg::AM_POST_INC)
						{nxt_cp, nxt_rf[`BATE_PAIR_Z + 5'h01], nxt_rf[`BATE_PAIR_Z]} = ext_z_inc;
				bate_pkg::OP_STACK_PUSH:
					nxt_sp = sp_ff - 16'h0001;
				bate_pkg::OP_STACK_POP:
					nxt_sp = sp_inc;
				default:
				begin
					if (is_shift)
					begin
						nxt_rf[op.dst] = sh[7:0];
						nxt_flags = shift_flags(flags_ff, sh[7:0], sh[8]);
					end
				end
			endcase
			// Pointer side effects of indirect accesses
			if (is_indirect && (op.mode == bate_pkg::AM_POST_INC))
				{nxt_rf[pbase + 5'h01], nxt_rf[pbase]} = ptr_inc;
			if (is_indirect && (op.mode == bate_pkg::AM_PRE_DEC))
				{nxt_rf[pbase + 5'h01], nxt_rf[pbase]} = ptr_dec;
		end
		if (st_ff == ST_LOAD)
			nxt_rf[pend_dst_ff] = dmem_rdata;
		if (st_ff == ST_PM_CAPTURE)
			nxt_rf[pend_dst_ff] = pmem_rdata;
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Cycle counts: loads and stores 2, code reads 3, code write until done
	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff)
			ST_IDLE:
			begin
				if (take)
				begin
					if (is_dload)
						nxt_st = ST_LOAD;
					else if (is_dstore)
						nxt_st = ST_TAIL;
					else if (is_io_bit)
						nxt_st = ST_IO_WRITE;
					else if (is_code)
						nxt_st = ST_PM_WAIT;
					else if (opc == bate_pkg::OP_CODE_WRITE)
						nxt_st = ST_SPM_WAIT;
				end
			end
			ST_PM_WAIT:
				nxt_st = ST_PM_CAPTURE;
			ST_SPM_WAIT:
				if (spm_done)
					nxt_st = ST_IDLE;
			ST_LOAD, ST_IO_WRITE, ST_TAIL, ST_PM_CAPTURE:
				nxt_st = ST_IDLE;
		endcase
	end

	// Destination of a pending load; implied code read goes to register 0
	wire logic [4:0] pend_dst = (is_code && op.implied) ? `BATE_REG_ZERO : op.dst;

	// Modified io byte: only the addressed bit changes
	wire logic [7:0] io_mod = (opc == bate_pkg::OP_IO_BIT_SET) ?
		(io_rdata | bit_mask(op.bit_sel)) : (io_rdata & ~bit_mask(op.bit_sel));

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Architectural state
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_ff <= ST_IDLE;
			rf_ff <= '0;
			flags_ff <= `BATE_FLAGS_RESET;
			sp_ff <= SP_RESET;
			cp_ff <= `BATE_CODE_PAGE_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
			rf_ff <= nxt_rf;
			flags_ff <= nxt_flags;
			sp_ff <= nxt_sp;
			cp_ff <= nxt_cp;
		end
	end

	// Operand capture for the later cycles of multi-cycle operations
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pend_dst_ff <= 5'h00;
			io_addr_ff <= 6'h00;
			io_byte_ff <= 8'h00;
		end
		else if (take)
		begin
			pend_dst_ff <= pend_dst;
			io_addr_ff <= op.io_addr;
			io_byte_ff <= io_mod;
		end
	end

	// Registered view port, one cycle behind the select
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			view_ff <= 8'h00;
		else
			view_ff <= rf_ff[view_sel];
	end

endmodule

// ### verif/bate_mem_model.sv
// Data space, I/O space and program store seen by the execution unit
`timescale 1ns/100ps
module bate_mem_model (
	input wire logic mclk,
	input wire bate_pkg::bate_mreq_t dmem_req,
	output logic [7:0] dmem_rdata,
	input wire bate_pkg::bate_mreq_t io_req,
	output logic [7:0] io_rdata,
	input wire bate_pkg::bate_preq_t pmem_req,
	output logic [7:0] pmem_rdata,
	input wire logic spm_req,
	output logic spm_done
);
	logic [7:0] mem [256];
	logic [7:0] io [64];
	logic [7:0] pbyte = 8'h00;
	logic [7:0] jk = 8'h55;
	logic [1:0] pcnt = 2'h0;
	logic [2:0] scnt = 3'h0;
	// Idle read lines carry a changing pattern, so no stale byte can pass
	assign io_rdata = io_req.re ? io[io_req.addr[5:0]] : jk;
	assign pmem_rdata = (pcnt != 2'h0) ? pbyte : jk;
	assign spm_done = (scnt == 3'h1);
	// Sync RAM, two-cycle program store and slow self-programming
	always @(posedge mclk)
	begin
		jk <= ~jk;
		dmem_rdata <= dmem_req.re ? mem[dmem_req.addr[7:0]] : jk;
		if (dmem_req.we)
			mem[dmem_req.addr[7:0]] <= dmem_req.wdata;
		if (io_req.we)
			io[io_req.addr[5:0]] <= io_req.wdata;
		if (pmem_req.re)
			pbyte <= pmem_req.addr[7:0] ^ pmem_req.addr[23:16] ^ 8'h3c;
		pcnt <= pmem_req.re ? 2'h2 : (pcnt != 2'h0 ? pcnt - 2'h1 : 2'h0);
		scnt <= spm_req ? 3'h3 : (scnt != 3'h0 ? scnt - 3'h1 : 3'h0);
	end
endmodule

// ### verif/bate_exec_asserts.sv
// Timing and side-effect properties of the execution unit
`timescale 1ns/100ps
module bate_exec_asserts (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire bate_pkg::bate_op_t op,
	input wire logic op_ready,
	input wire bate_pkg::bate_mreq_t dmem_req,
	input wire bate_pkg::bate_mreq_t io_req,
	input wire bate_pkg::bate_preq_t pmem_req,
	input wire logic [7:0] status_flags,
	input wire logic [15:0] stack_ptr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Operation accepted at this edge
	wire logic take = op_valid && op_ready;
	load_busy_a: assert property (take && op.opc == bate_pkg::OP_INDIRECT_LOAD |->
		dmem_req.re ##1 !op_ready ##1 op_ready) else $error("load timing wrong");
	io_set_a: assert property (take && op.opc == bate_pkg::OP_IO_BIT_SET |-> io_req.re ##1
		io_req.we && !op_ready && io_req.wdata[$past(op.bit_sel)]) else $error("bit set wrong");
	code_wait_a: assert property (take && op.opc == bate_pkg::OP_CODE_READ |->
		pmem_req.re ##1 !op_ready [*2] ##1 op_ready) else $error("code read timing wrong");
	swap_flags_a: assert property (take && op.opc == bate_pkg::OP_NIBBLE_EXCHANGE |=>
		$stable(status_flags) && op_ready) else $error("swap altered flags");
	flag_set_a: assert property (take && op.opc == bate_pkg::OP_FLAG_SET |=>
		status_flags == ($past(status_flags) | (8'h01 << $past(op.bit_sel))))
		else $error("flag set wrong");
	push_sp_a: assert property (take && op.opc == bate_pkg::OP_STACK_PUSH |->
		dmem_req.we && dmem_req.addr == stack_ptr ##1 stack_ptr == $past(stack_ptr) - 16'h1)
		else $error("push wrong");
	pop_addr_a: assert property (take && op.opc == bate_pkg::OP_STACK_POP |->
		dmem_req.re && dmem_req.addr == stack_ptr + 16'h1) else $error("pop address wrong");
	dstore_a: assert property (take && op.opc == bate_pkg::OP_DIRECT_STORE |->
		dmem_req.we && dmem_req.addr == op.addr ##1 !op_ready) else $error("direct store wrong");
	move_one_a: assert property (take && op.opc == bate_pkg::OP_REG_MOVE |=>
		op_ready && $stable(status_flags)) else $error("move not single cycle");
	io_clear_a: assert property (take && op.opc == bate_pkg::OP_IO_BIT_CLEAR |->
		io_req.re ##1 io_req.we && !op_ready && !io_req.wdata[$past(op.bit_sel)] &&
		$stable(status_flags)) else $error("bit clear wrong");
	shift_keep_a: assert property (take && op.opc == bate_pkg::OP_LOGICAL_LEFT_SHIFT |=>
		op_ready && status_flags[7:4] == $past(status_flags[7:4]))
		else $error("shift touched upper flags");
endmodule
bind bate_exec bate_exec_asserts u_chk (.mclk, .nrst, .op_valid, .op, .op_ready, .dmem_req,
	.io_req, .pmem_req, .status_flags, .stack_ptr);

// ### verif/bate_exec_tb_top.sv
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`include "bate_consts.svh"
module bate_exec_tb_top;
	logic mclk, nrst, op_valid, op_ready, spm_req, spm_done;
	logic [7:0] dmem_rdata, io_rdata, pmem_rdata, status_flags, code_page, view_data, f;
	logic [15:0] spm_addr, spm_word, stack_ptr;
	logic [4:0] view_sel;
	bate_pkg::bate_op_t op, cur;
	bate_pkg::bate_mreq_t dmem_req, io_req;
	bate_pkg::bate_preq_t pmem_req;
	int n_errors = 0;
	int compares = 0;
	bate_exec u_dut (.mclk, .nrst, .op_valid, .op, .op_ready, .dmem_req, .dmem_rdata, .io_req,
		.io_rdata, .pmem_req, .pmem_rdata, .spm_req, .spm_addr, .spm_word, .spm_done,
		.status_flags, .code_page, .stack_ptr, .view_sel, .view_data);
	bate_mem_model u_mem (.mclk, .dmem_req, .dmem_rdata, .io_req, .io_rdata, .pmem_req,
		.pmem_rdata, .spm_req, .spm_done);
	// Free-running clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic test_done();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	// Offer one operation for one cycle, then wait for idle under a bound
	task automatic go(input bate_pkg::bate_opc_t c);
		int n;
		@(negedge mclk);
		cur.opc = c;
		op = cur;
		op_valid = 1'b1;
		@(negedge mclk);
		op_valid = 1'b0;
		n = 0;
		while (op_ready !== 1'b1 && n < 20)
		begin
			@(negedge mclk);
			n++;
		end
		// A sequencer that never returns to idle counts as a mismatch
		if (op_ready !== 1'b1)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, op_ready, 1'b1);
			n_errors++;
		end
	endtask
	task automatic set(input logic [4:0] r, input logic [7:0] v);
		cur.dst = r;
		cur.imm = v;
		go(bate_pkg::OP_IMMEDIATE_LOAD);
	endtask
	// Register view is one cycle behind its select
	task automatic ck_reg(input logic [4:0] r, input logic [7:0] v);
		view_sel = r;
		@(negedge mclk);
		chk(view_data, v);
	endtask
	task automatic t_shift();
		bate_pkg::bate_opc_t oc[6] = '{bate_pkg::OP_LOGICAL_LEFT_SHIFT,
			bate_pkg::OP_LOGICAL_RIGHT_SHIFT, bate_pkg::OP_CARRY_ROTATE_LEFT,
			bate_pkg::OP_CARRY_ROTATE_RIGHT, bate_pkg::OP_SIGN_RIGHT_SHIFT,
			bate_pkg::OP_CARRY_ROTATE_LEFT};
		// Input, result, carry in, then V N Z C after
		logic [23:0] tv[6] = '{24'h810209, 24'h01000b, 24'h800119, 24'h018015, 24'h81c005,
			24'h40800c};
		for (int i = 0; i < 6; i++)
		begin
			set(5'h10, tv[i][23:16]);
			cur.bit_sel = 3'h0;
			go(tv[i][4] ? bate_pkg::OP_FLAG_SET : bate_pkg::OP_FLAG_CLEAR);
			f = status_flags;
			go(oc[i]);
			ck_reg(5'h10, tv[i][15:8]);
			chk(status_flags, {f[7:4], tv[i][3:0]});
		end
		set(5'h10, 8'h3c);
		f = status_flags;
		go(bate_pkg::OP_NIBBLE_EXCHANGE);
		ck_reg(5'h10, 8'hc3);
		chk(status_flags, f);
		$display("done shift");
	endtask
	task automatic t_flags();
		for (int b = 0; b < 8; b++)
		begin
			cur.bit_sel = 3'(b);
			f = status_flags;
			go(bate_pkg::OP_FLAG_SET);
			chk(status_flags, f | (8'h01 << b));
			go(bate_pkg::OP_FLAG_CLEAR);
			chk(status_flags, f & ~(8'h01 << b));
		end
		set(5'h05, 8'h04);
		cur.src = 5'h05;
		cur.bit_sel = 3'h2;
		f = status_flags;
		go(bate_pkg::OP_BIT_TO_TFLAG);
		chk(status_flags, f | 8'h40);
		cur.dst = 5'h06;
		cur.bit_sel = 3'h7;
		go(bate_pkg::OP_TFLAG_TO_BIT);
		ck_reg(5'h06, 8'h80);
		$display("done flags");
	endtask
	task automatic t_io();
		u_mem.io[5] = 8'h0f;
		cur.io_addr = 6'h05;
		cur.bit_sel = 3'h7;
		f = status_flags;
		go(bate_pkg::OP_IO_BIT_SET);
		chk(u_mem.io[5], 8'h8f);
		cur.bit_sel = 3'h0;
		go(bate_pkg::OP_IO_BIT_CLEAR);
		chk(u_mem.io[5], 8'h8e);
		chk(status_flags, f);
		cur.dst = 5'h0c;
		go(bate_pkg::OP_PORT_READ);
		ck_reg(5'h0c, 8'h8e);
		$display("done io");
	endtask
	task automatic t_data();
		u_mem.mem[8'h10] = 8'ha5;
		u_mem.mem[8'h23] = 8'h3c;
		u_mem.mem[8'h40] = 8'h77;
		set(5'h1e, 8'h10);
		set(5'h1c, 8'h20);
		set(5'h1a, 8'h30);
		cur.ptr = bate_pkg::PTR_Z;
		cur.mode = bate_pkg::AM_POST_INC;
		cur.dst = 5'h01;
		go(bate_pkg::OP_INDIRECT_LOAD);
		ck_reg(5'h01, 8'ha5);
		ck_reg(5'h1e, 8'h11);
		cur.mode = bate_pkg::AM_PRE_DEC;
		cur.dst = 5'h02;
		go(bate_pkg::OP_INDIRECT_LOAD);
		ck_reg(5'h02, 8'ha5);
		ck_reg(5'h1e, 8'h10);
		cur.ptr = bate_pkg::PTR_Y;
		cur.mode = bate_pkg::AM_DISP;
		cur.disp = 6'h03;
		cur.dst = 5'h03;
		go(bate_pkg::OP_INDIRECT_LOAD);
		ck_reg(5'h03, 8'h3c);
		ck_reg(5'h1c, 8'h20);
		cur.ptr = bate_pkg::PTR_X;
		cur.mode = bate_pkg::AM_POST_INC;
		cur.src = 5'h01;
		go(bate_pkg::OP_INDIRECT_STORE);
		chk(u_mem.mem[8'h30], 8'ha5);
		ck_reg(5'h1a, 8'h31);
		cur.mode = bate_pkg::AM_PRE_DEC;
		cur.src = 5'h03;
		go(bate_pkg::OP_INDIRECT_STORE);
		chk(u_mem.mem[8'h30], 8'h3c);
		ck_reg(5'h1a, 8'h30);
		cur.ptr = bate_pkg::PTR_Z;
		cur.mode = bate_pkg::AM_DISP;
		cur.disp = 6'h05;
		cur.src = 5'h02;
		go(bate_pkg::OP_INDIRECT_STORE);
		chk(u_mem.mem[8'h15], 8'ha5);
		cur.addr = 16'h0040;
		cur.dst = 5'h04;
		go(bate_pkg::OP_DIRECT_LOAD);
		ck_reg(5'h04, 8'h77);
		cur.addr = 16'h0041;
		cur.src = 5'h04;
		go(bate_pkg::OP_DIRECT_STORE);
		chk(u_mem.mem[8'h41], 8'h77);
		// Plain indirect form reads at the pointer and leaves it alone
		cur.mode = bate_pkg::AM_PLAIN;
		cur.dst = 5'h09;
		go(bate_pkg::OP_INDIRECT_LOAD);
		ck_reg(5'h09, 8'ha5);
		ck_reg(5'h1e, 8'h10);
		cur.dst = 5'h0e;
		cur.src = 5'h09;
		f = status_flags;
		go(bate_pkg::OP_REG_MOVE);
		ck_reg(5'h0e, 8'ha5);
		chk(status_flags, f);
		cur.dst = 5'h0a;
		cur.src = 5'h1e;
		go(bate_pkg::OP_PAIR_COPY);
		ck_reg(5'h0a, 8'h10);
		ck_reg(5'h0b, 8'h00);
		$display("done data");
	endtask
	task automatic t_code();
		cur.implied = 1'b1;
		cur.mode = bate_pkg::AM_POST_INC;
		go(bate_pkg::OP_CODE_READ);
		ck_reg(5'h00, 8'h2c);
		ck_reg(5'h1e, 8'h11);
		cur.implied = 1'b0;
		set(5'h0d, 8'h02);
		cur.io_addr = `BATE_CODE_PAGE_IO;
		cur.src = 5'h0d;
		go(bate_pkg::OP_PORT_WRITE);
		chk(code_page, 8'h02);
		set(5'h1e, 8'hff);
		set(5'h1f, 8'hff);
		cur.dst = 5'h07;
		go(bate_pkg::OP_EXT_CODE_READ);
		ck_reg(5'h07, 8'hc1);
		chk(code_page, 8'h03);
		ck_reg(5'h1f, 8'h00);
		$display("done code");
	endtask
	task automatic t_stack();
		cur.src = 5'h04;
		go(bate_pkg::OP_STACK_PUSH);
		chk(u_mem.mem[8'hff], 8'h77);
		chk(stack_ptr, 16'hfffe);
		cur.dst = 5'h08;
		go(bate_pkg::OP_STACK_POP);
		ck_reg(5'h08, 8'h77);
		chk(stack_ptr, 16'hffff);
		set(5'h00, 8'h34);
		set(5'h01, 8'h12);
		set(5'h1e, 8'h20);
		go(bate_pkg::OP_CODE_WRITE);
		chk(spm_word, 16'h1234);
		chk(spm_addr, 16'h0020);
		$display("done stack");
	endtask
	// Reset in mid-run must bring back the page, flags, SP and a cleared register 8, then accept work at once
	task automatic t_reset();
		@(negedge mclk);
		nrst = 1'b0;
		@(negedge mclk);
		nrst = 1'b1;
		chk(code_page, `BATE_CODE_PAGE_RESET);
		chk(status_flags, `BATE_FLAGS_RESET);
		chk(stack_ptr, `BATE_SP_RESET);
		ck_reg(5'h08, 8'h00);
		set(5'h08, 8'h5a);
		ck_reg(5'h08, 8'h5a);
		$display("done reset");
	endtask
	// Hang guard, about fifteen times the expected run length
	initial
	begin
		#(8 * 3000);
		n_errors++;
		test_done();
	end
	initial
	begin
		nrst = 1'b0;
		op_valid = 1'b0;
		op = '0;
		cur = '0;
		view_sel = 5'h00;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		nrst = 1'b1;
		chk(stack_ptr, `BATE_SP_RESET);
		chk(op_ready, 1'b1);
		t_shift();
		t_flags();
		t_io();
		t_data();
		t_code();
		t_stack();
		t_reset();
		test_done();
	end
endmodule
